/* logic/lfs_pkg.sv */
package lfs_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
   localparam logic [7:0] ERR_LIM_OFS  = 8'h10;
   localparam logic [7:0] BIAS_SET_OFS = 8'h14;
   localparam logic [7:0] MAX_CUR_OFS  = 8'h18;
   localparam logic [7:0] TEMP_RD_OFS  = 8'h1C;
   localparam logic [7:0] TEMP_SET_OFS = 8'h20;

   // Control register bit positions.
   localparam int CTRL_CUR_ON  = 0;
   localparam int CTRL_CUR_OFF = 1;
   localparam int CTRL_TSTAB   = 2;
   localparam int CTRL_MOD_EN  = 3;
   localparam int CTRL_SYNC_SEL = 4;

   // Event bit positions, shared by irq status and mask.
   localparam int EV_VLAS   = 0;
   localparam int EV_SUPPLY = 1;
   localparam int EV_LINK   = 2;
   localparam int EV_SENSOR = 3;
   localparam int EV_STAB   = 4;
   localparam int EV_TRIP   = 5;
   localparam int EV_W      = 6;

   // Reset values.
   localparam logic [31:0] ERR_LIM_RST  = 32'h0010_0000;
   localparam logic [15:0] MAX_CUR_RST  = 16'h0000;
   localparam logic [31:0] TEMP_SET_RST = 32'h0000_61A8;

   // Analog thresholds in mV and milli-degrees: 18.5 V, -273 and -67.737.
   localparam logic [15:0] UV_LIMIT_MV   = 16'h4844;
   localparam int          CL_GAIN_X100  = 77;
   localparam int          CL_OFS_X100MV = 100000;
   localparam logic signed [31:0] TEMP_LINK_FAIL_MC   = 32'shFFFB_D598;
   localparam logic signed [31:0] TEMP_SENSOR_FAIL_MC = 32'shFFFE_F767;

   // Modulation hold-off after current on.
   localparam longint CLK_HZ     = 200_000_000;
   localparam longint MOD_HOLD_S = 10;
   localparam logic [31:0] MOD_HOLD_CYC = 32'(MOD_HOLD_S * CLK_HZ);

   typedef enum logic [1:0] {
      CG_OFF    = 2'b00,
      CG_SETTLE = 2'b01,
      CG_RUN    = 2'b10
   } lfs_cg_state_t;
endpackage

/* logic/lfs_compliance.sv */
module lfs_compliance (
   input  wire logic        core_clk,   // System clock.
   input  wire logic        reset,      // Async reset, active high.
   input  wire logic [15:0] vlas_mv,    // Laser voltage, mV.
   input  wire logic [15:0] vcc_mv,     // Source supply voltage, mV.
   output logic             over_cl,    // Laser voltage above limit.
   output logic             under_vcc   // Supply below threshold.
);
   import lfs_pkg::*;

   logic signed [31:0] lhs_x100;
   logic signed [31:0] lim_x100;

   // Limit is 0.77 * supply - 1 V, scaled by 100 to stay integer.
   assign lhs_x100 = $signed({16'h0000, vlas_mv}) * 32'sd100;
   assign lim_x100 = $signed({16'h0000, vcc_mv}) * 32'(CL_GAIN_X100)
                     - 32'(CL_OFS_X100MV);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         over_cl   <= 1'b0;
         under_vcc <= 1'b0;
      end else begin
         over_cl   <= lhs_x100 > lim_x100;
         under_vcc <= vcc_mv < UV_LIMIT_MV;
      end
   end
endmodule

/* logic/lfs_stab_accum.sv */
module lfs_stab_accum (
   input  wire logic               core_clk,  // System clock.
   input  wire logic               reset,     // Async reset, active high.
   input  wire logic               enable,    // Stabilization active.
   input  wire logic               sample_vld, // New temperature sample.
   input  wire logic signed [31:0] temp_mc,   // Measured, milli-degrees.
   input  wire logic signed [31:0] set_mc,    // Setpoint, milli-degrees.
   input  wire logic [31:0]        limit,     // Error sum limit.
   output logic                    fail       // Sum above limit.
);
   logic signed [32:0] err;
   logic [32:0]        err_abs;
   logic [39:0]        sum_q;
   logic               neg_q;

   assign err     = 33'(temp_mc) - 33'(set_mc);
   assign err_abs = err[32] ? 33'(-err) : 33'(err);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sum_q <= 40'h00_0000_0000;
         neg_q <= 1'b0;
      end else if (!enable) begin
         sum_q <= 40'h00_0000_0000;
      end else if (sample_vld) begin
         neg_q <= err[32];
         if (err[32] != neg_q) begin
            sum_q <= 40'h00_0000_0000;
         end else begin
            sum_q <= sum_q + 40'(err_abs);
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fail <= 1'b0;
      end else begin
         fail <= enable && (sum_q > {8'h00, limit});
      end
   end
endmodule

/* logic/lfs_supervisor.sv */
// Functional notes
// - Open circuit: bias off, short, voltage warning.
// - Voltage above compliance limit raises voltage warning.
// - Supply under 18.5 V: bias off, short, warning.
// - Current generator fault flags are sticky.
// - Current-on command clears sticky fault flags.
// - Link failure reports -273 degrees plus warning.
// - Link warning clears when communication returns.
// - Sensor fault reports -67.737 degrees plus warning.
// - Link or sensor fault under stabilization warns reading.
// - Temperature fault while sourcing disables current.
// - Stabilization failure stops stabilization and current.
// - Programmable error sum limit declares stabilization failure.
// - Maximum limit clamps only the bias setpoint.
// - Sync output follows selected synthesizer channel.
// - Error sum accumulates, resets on setpoint crossing.
// - Modulation held off 10 s; drops with current.
module lfs_supervisor
  import lfs_pkg::*;
#(
   parameter logic [31:0] MOD_HOLD_CYCLES = lfs_pkg::MOD_HOLD_CYC
) (
   input  wire logic        core_clk,        // System clock, 200 MHz.
   input  wire logic        reset,           // Async reset, active high.
   input  wire logic        psel,            // APB select.
   input  wire logic        penable,         // APB access phase.
   input  wire logic        pwrite,          // APB write.
   input  wire logic [7:0]  paddr,           // APB byte address.
   input  wire logic [31:0] pwdata,          // APB write data.
   output logic [31:0]      prdata,          // APB read data.
   output logic             pready,          // APB ready.
   output logic             pslverr,         // APB error, unmapped.
   input  wire logic        open_circuit,    // Laser connection lost.
   input  wire logic [15:0] vlas_mv,         // Laser voltage, mV.
   input  wire logic [15:0] vcc_mv,          // Module supply, mV.
   input  wire logic        temp_link_ok,    // Temperature module talks.
   input  wire logic        sensor_ok,       // Temperature sensor sane.
   input  wire logic        temp_vld,        // New temperature sample.
   input  wire logic [31:0] temp_mc,         // Temperature, milli-deg.
   input  wire logic        synth_channel_one, // Channel one square.
   input  wire logic        synth_channel_two, // Channel two square.
   output logic             cur_gen_en,      // Bias generator enable.
   output logic             output_short,    // Short output connector.
   output logic [15:0]      bias_set,        // Clamped bias setpoint.
   output logic             tstab_en,        // Temperature stabilization.
   output logic             modulation_enable, // Modulation allowed.
   output logic             sync_out,        // Square sync output.
   output logic [31:0]      temp_read,       // Reported temperature.
   output logic             irq              // Level interrupt.
);
   import lfs_pkg::*;

   lfs_cg_state_t     cg_q;
   logic [31:0]       hold_q;
   logic              vlas_warn_q;
   logic              supply_warn_q;
   logic              stab_fail_q;
   logic              tstab_q;
   logic              mod_req_q;
   logic              sync_sel_q;
   logic [EV_W-1:0]   irq_stat_q;
   logic [EV_W-1:0]   irq_mask_q;
   logic [31:0]       err_lim_q;
   logic [15:0]       bias_q;
   logic [15:0]       max_cur_q;
   logic [31:0]       temp_set_q;
   logic [31:0]       prdata_q;
   logic              link_prev_q;
   logic              sensor_prev_q;
   logic              over_cl;
   logic              under_vcc;
   logic              stab_fail;
   logic              wr;
   logic              rd_setup;
   logic              cmd_on;
   logic              cmd_off;
   logic              ctrl_wr;
   logic              cg_fault;
   logic              temp_fault;
   logic              shutdown;
   logic              tempread_warn;
   logic [EV_W-1:0]   events;
   logic [31:0]       status_word;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == CTRL_OFS) || (a == STATUS_OFS) ||
               (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS) ||
               (a == ERR_LIM_OFS) || (a == BIAS_SET_OFS) ||
               (a == MAX_CUR_OFS) || (a == TEMP_RD_OFS) ||
               (a == TEMP_SET_OFS);
   endfunction

   lfs_compliance u_cl (
      .core_clk  (core_clk),
      .reset     (reset),
      .vlas_mv   (vlas_mv),
      .vcc_mv    (vcc_mv),
      .over_cl   (over_cl),
      .under_vcc (under_vcc)
   );

   lfs_stab_accum u_acc (
      .core_clk   (core_clk),
      .reset      (reset),
      .enable     (tstab_q),
      .sample_vld (temp_vld && temp_link_ok && sensor_ok),
      .temp_mc    (temp_mc),
      .set_mc     (temp_set_q),
      .limit      (err_lim_q),
      .fail       (stab_fail)
   );

   // APB decode. Reads are captured in the setup cycle, so the answer
   // comes with pready in the first access cycle.
   assign wr       = psel && penable && pwrite && mapped(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   assign ctrl_wr  = wr && (paddr == CTRL_OFS);
   assign cmd_on   = ctrl_wr && pwdata[CTRL_CUR_ON];
   assign cmd_off  = ctrl_wr && pwdata[CTRL_CUR_OFF];
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped(paddr);
   assign prdata   = prdata_q;

   assign cg_fault   = open_circuit || over_cl || under_vcc;
   assign temp_fault = !temp_link_ok || !sensor_ok || stab_fail;
   // Open circuit and low supply both trip the generator.
   assign shutdown   = open_circuit || under_vcc || temp_fault;
   assign tempread_warn = (tstab_q && (!temp_link_ok || !sensor_ok))
                          || stab_fail_q;

   assign events[EV_VLAS]   = open_circuit || over_cl;
   assign events[EV_SUPPLY] = under_vcc;
   assign events[EV_LINK]   = !temp_link_ok && link_prev_q;
   assign events[EV_SENSOR] = !sensor_ok && sensor_prev_q;
   assign events[EV_STAB]   = stab_fail && tstab_q;
   assign events[EV_TRIP]   = shutdown && (cg_q != CG_OFF);

   assign status_word = {21'h00_0000, sync_sel_q, stab_fail_q,
                         tempread_warn, !sensor_ok, !temp_link_ok,
                         supply_warn_q, vlas_warn_q, modulation_enable,
                         tstab_q, cur_gen_en, (cg_q == CG_SETTLE)};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prdata_q <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (paddr)
            CTRL_OFS:     prdata_q <= {27'h000_0000, sync_sel_q, mod_req_q,
                                       tstab_q, 2'b00};
            STATUS_OFS:   prdata_q <= status_word;
            IRQ_STAT_OFS: prdata_q <= 32'(irq_stat_q);
            IRQ_MASK_OFS: prdata_q <= 32'(irq_mask_q);
            ERR_LIM_OFS:  prdata_q <= err_lim_q;
            BIAS_SET_OFS: prdata_q <= {16'h0000, bias_q};
            MAX_CUR_OFS:  prdata_q <= {16'h0000, max_cur_q};
            TEMP_RD_OFS:  prdata_q <= temp_read;
            TEMP_SET_OFS: prdata_q <= temp_set_q;
            default:      prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Plain configuration registers.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         err_lim_q  <= ERR_LIM_RST;
         bias_q     <= 16'h0000;
         max_cur_q  <= MAX_CUR_RST;
         temp_set_q <= TEMP_SET_RST;
         irq_mask_q <= {EV_W{1'b0}};
         mod_req_q  <= 1'b0;
         sync_sel_q <= 1'b0;
      end else if (wr) begin
         case (paddr)
            ERR_LIM_OFS:  err_lim_q  <= pwdata;
            BIAS_SET_OFS: bias_q     <= pwdata[15:0];
            MAX_CUR_OFS:  max_cur_q  <= pwdata[15:0];
            TEMP_SET_OFS: temp_set_q <= pwdata;
            IRQ_MASK_OFS: irq_mask_q <= pwdata[EV_W-1:0];
            CTRL_OFS: begin
               mod_req_q  <= pwdata[CTRL_MOD_EN];
               sync_sel_q <= pwdata[CTRL_SYNC_SEL];
            end
            default: begin
            end
         endcase
      end
   end

   // Current generator state. A shutdown cause (open circuit, low supply,
   // temperature fault) in the same cycle as a current-on request keeps
   // the generator off; over-voltage alone does not.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cg_q   <= CG_OFF;
         hold_q <= 32'h0000_0000;
      end else begin
         case (cg_q)
            CG_OFF: begin
               if (cmd_on && !shutdown && !cmd_off) begin
                  cg_q   <= CG_SETTLE;
                  hold_q <= 32'h0000_0000;
               end
            end
            CG_SETTLE: begin
               if (shutdown || cmd_off) begin
                  cg_q <= CG_OFF;
               end else if (hold_q >= MOD_HOLD_CYCLES - 32'h0000_0001) begin
                  cg_q <= CG_RUN;
               end else begin
                  hold_q <= hold_q + 32'h0000_0001;
               end
            end
            CG_RUN: begin
               if (shutdown || cmd_off) begin
                  cg_q <= CG_OFF;
               end
            end
            default: cg_q <= CG_OFF;
         endcase
      end
   end

   // Sticky generator flags: the command clears, a live cause sets and
   // wins over the clear.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         vlas_warn_q   <= 1'b0;
         supply_warn_q <= 1'b0;
      end else begin
         vlas_warn_q   <= (open_circuit || over_cl) ||
                          (vlas_warn_q && !cmd_on);
         supply_warn_q <= under_vcc ||
                          (supply_warn_q && !cmd_on);
      end
   end

   // Stabilization enable and its failure flag.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tstab_q     <= 1'b0;
         stab_fail_q <= 1'b0;
      end else begin
         if (stab_fail) begin
            tstab_q <= 1'b0;
         end else if (ctrl_wr) begin
            tstab_q <= pwdata[CTRL_TSTAB];
         end
         stab_fail_q <= stab_fail ||
                        (stab_fail_q && !(ctrl_wr && pwdata[CTRL_TSTAB]));
      end
   end

   // Reported temperature, substituted on link or sensor faults.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         temp_read     <= 32'h0000_0000;
         link_prev_q   <= 1'b1;
         sensor_prev_q <= 1'b1;
      end else begin
         link_prev_q   <= temp_link_ok;
         sensor_prev_q <= sensor_ok;
         if (!temp_link_ok) begin
            temp_read <= TEMP_LINK_FAIL_MC;
         end else if (!sensor_ok) begin
            temp_read <= TEMP_SENSOR_FAIL_MC;
         end else if (temp_vld) begin
            temp_read <= temp_mc;
         end
      end
   end

   // Interrupt status, write one to clear; a new event wins.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_stat_q <= {EV_W{1'b0}};
      end else begin
         irq_stat_q <= events | (irq_stat_q &
                       ~((wr && paddr == IRQ_STAT_OFS) ?
                         pwdata[EV_W-1:0] : {EV_W{1'b0}}));
      end
   end

   // Outputs that drive the analog side.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         bias_set <= 16'h0000;
         sync_out <= 1'b0;
         irq      <= 1'b0;
      end else begin
         bias_set <= (bias_q > max_cur_q) ? max_cur_q : bias_q;
         sync_out <= sync_sel_q ? synth_channel_two
                                : synth_channel_one;
         irq      <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Enable and short follow the state directly so a trip lands at once.
   assign cur_gen_en   = (cg_q != CG_OFF);
   assign output_short = !cur_gen_en;
   assign tstab_en     = tstab_q;
   assign modulation_enable = (cg_q == CG_RUN) && mod_req_q;

   chk_open_trip: assert property (
      @(posedge core_clk) disable iff (reset)
      open_circuit |=> !cur_gen_en && output_short)
      else $error("open circuit did not trip generator");

   chk_supply_flag: assert property (
      @(posedge core_clk) disable iff (reset)
      under_vcc |=> supply_warn_q)
      else $error("supply warning not raised");

   chk_sticky_hold: assert property (
      @(posedge core_clk) disable iff (reset)
      (vlas_warn_q && !cmd_on) |=> vlas_warn_q)
      else $error("voltage warning dropped without command");

   chk_on_clears: assert property (
      @(posedge core_clk) disable iff (reset)
      (cmd_on && !under_vcc) |=> !supply_warn_q)
      else $error("current-on did not clear supply flag");

   chk_link_value: assert property (
      @(posedge core_clk) disable iff (reset)
      !temp_link_ok |=> temp_read == TEMP_LINK_FAIL_MC)
      else $error("link fault temperature wrong");

   chk_sensor_value: assert property (
      @(posedge core_clk) disable iff (reset)
      (temp_link_ok && !sensor_ok) |=> temp_read == TEMP_SENSOR_FAIL_MC)
      else $error("sensor fault temperature wrong");

   chk_temp_trip: assert property (
      @(posedge core_clk) disable iff (reset)
      (temp_fault && cur_gen_en) |=> !cur_gen_en)
      else $error("temperature fault left current on");

   chk_stab_stop: assert property (
      @(posedge core_clk) disable iff (reset)
      stab_fail |=> !tstab_en && tempread_warn)
      else $error("stabilization failure not handled");

   chk_bias_clamp: assert property (
      @(posedge core_clk) disable iff (reset)
      ##1 bias_set == (($past(bias_q) > $past(max_cur_q)) ?
                       $past(max_cur_q) : $past(bias_q)))
      else $error("bias setpoint not clamped");

   chk_mod_block: assert property (
      @(posedge core_clk) disable iff (reset)
      $rose(cur_gen_en) |-> !modulation_enable [*8])
      else $error("modulation allowed during hold-off");

   chk_on_priority: assert property (
      @(posedge core_clk) disable iff (reset)
      (cmd_on && shutdown && !cur_gen_en) |=> !cur_gen_en)
      else $error("current-on beat a fault");

   cov_trip: cover property (@(posedge core_clk) disable iff (reset)
      cur_gen_en ##1 !cur_gen_en ##[1:20] vlas_warn_q);
   cov_run: cover property (@(posedge core_clk) disable iff (reset)
      modulation_enable);
   cov_stab: cover property (@(posedge core_clk) disable iff (reset)
      $rose(stab_fail_q));
endmodule

/* tb/lfs_far_model.sv */
module lfs_far_model (
   input  wire logic        core_clk,          // System clock.
   input  wire logic        reset,             // Async reset, active high.
   input  wire logic        link_up,           // Temperature module alive.
   input  wire logic [31:0] temp_now,          // Laser temperature, mC.
   output logic             temp_vld,          // Sample strobe.
   output logic [31:0]      temp_mc,           // Sample value.
   output logic             synth_channel_one, // Channel one square.
   output logic             synth_channel_two  // Channel two square.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt_q;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   assign temp_vld = link_up && (cnt_q[2:0] == 3'h7);
   // A silent link leaves the sample bus floating, shown as churn.
   assign temp_mc = link_up ? temp_now : {4{cnt_q}};
   assign synth_channel_one = cnt_q[2];
   assign synth_channel_two = cnt_q[3];
endmodule

/* tb/test_laser_driver_fault_supervisor.sv */
module test_laser_driver_fault_supervisor;
   timeunit 1ns;
   timeprecision 100ps;
   import lfs_pkg::*;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic        e;
   } lfs_exp_t;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        open_circuit = 1'b0, temp_link_ok = 1'b1, sensor_ok = 1'b1;
   logic [15:0] vlas_mv = 16'h07D0, vcc_mv = 16'h5DC0;
   logic [31:0] temp_now = 32'h0000_61E4;
   logic [31:0] prdata, temp_mc, temp_read;
   logic [15:0] bias_set, mx, bs;
   logic        pready, pslverr, temp_vld, ch1, ch2, cur_gen_en, irq;
   logic        output_short, tstab_en, modulation_enable, sync_out, v;
   lfs_exp_t    exq[$];
   lfs_exp_t    me;
   int          mismatches = 0, checks = 0, cycles = 0;

   always #2.5 core_clk = ~core_clk;

   lfs_far_model u_far (.core_clk(core_clk), .reset(reset),
      .link_up(temp_link_ok), .temp_now(temp_now), .temp_vld(temp_vld),
      .temp_mc(temp_mc), .synth_channel_one(ch1), .synth_channel_two(ch2));

   lfs_supervisor #(.MOD_HOLD_CYCLES(32'h14)) u_dut (.core_clk(core_clk),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .open_circuit(open_circuit), .vlas_mv(vlas_mv),
      .vcc_mv(vcc_mv), .temp_link_ok(temp_link_ok), .sensor_ok(sensor_ok),
      .temp_vld(temp_vld), .temp_mc(temp_mc), .synth_channel_one(ch1),
      .synth_channel_two(ch2), .cur_gen_en(cur_gen_en),
      .output_short(output_short), .bias_set(bias_set),
      .tstab_en(tstab_en), .modulation_enable(modulation_enable),
      .sync_out(sync_out), .temp_read(temp_read), .irq(irq));

   task automatic tally_and_finish();
      if (mismatches == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] d, input logic e);
      exq.push_back('{d: d, m: m, e: e});
      apb(1'b0, a, 32'h0);
   endtask

   // Read results are judged at the access edge, oldest note first.
   always @(posedge core_clk) begin
      cycles++;
      if (psel && penable && pready === 1'b1 && !pwrite &&
          exq.size() > 0) begin
         me = exq.pop_front();
         chk(prdata & me.m, me.d);
         chk({31'h0, pslverr}, {31'h0, me.e});
      end
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(68096));
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      cyc(2);
      chk(cur_gen_en, 32'h0);
      chk(output_short, 32'h1);
      rd(ERR_LIM_OFS, 32'hFFFF_FFFF, ERR_LIM_RST, 1'b0);
      rd(MAX_CUR_OFS, 32'h0000_FFFF, 32'h0, 1'b0);
      rd(TEMP_SET_OFS, 32'hFFFF_FFFF, TEMP_SET_RST, 1'b0);
      rd(8'h40, 32'hFFFF_FFFF, 32'h0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         mx = 16'($urandom);
         bs = (i == 0) ? mx : 16'($urandom);
         apb(1'b1, MAX_CUR_OFS, {16'h0, mx});
         apb(1'b1, BIAS_SET_OFS, {16'h0, bs});
         cyc(2);
         chk(bias_set, (bs > mx) ? mx : bs);
      end
      apb(1'b1, IRQ_MASK_OFS, 32'h3F);
      // Host sends current-on with stabilization active, no prompt needed.
      apb(1'b1, CTRL_OFS, 32'h0D);
      chk(cur_gen_en, 32'h1);
      chk(modulation_enable, 32'h0);
      cyc(30);
      chk(modulation_enable, 32'h1);
      rd(STATUS_OFS, 32'h0F, 32'h0E, 1'b0);
      temp_link_ok <= 1'b0;
      cyc(3);
      chk(cur_gen_en, 32'h0);
      chk(modulation_enable, 32'h0);
      chk(temp_read, TEMP_LINK_FAIL_MC);
      rd(STATUS_OFS, 32'h1C0, 32'h140, 1'b0);
      temp_link_ok <= 1'b1;
      cyc(3);
      rd(STATUS_OFS, 32'h40, 32'h0, 1'b0);
      apb(1'b1, IRQ_MASK_OFS, 32'h0);
      sensor_ok <= 1'b0;
      cyc(3);
      chk(temp_read, TEMP_SENSOR_FAIL_MC);
      chk(irq, 32'h0);
      sensor_ok <= 1'b1;
      apb(1'b1, IRQ_MASK_OFS, 32'h3F);
      cyc(2);
      chk(irq, 32'h1);
      rd(IRQ_STAT_OFS, 32'h3F, 32'h2C, 1'b0);
      apb(1'b1, IRQ_STAT_OFS, 32'h3F);
      cyc(2);
      chk(irq, 32'h0);
      apb(1'b1, CTRL_OFS, 32'h05);
      open_circuit <= 1'b1;
      apb(1'b1, CTRL_OFS, 32'h05);
      cyc(1);
      chk(cur_gen_en, 32'h0);
      chk(output_short, 32'h1);
      open_circuit <= 1'b0;
      cyc(2);
      rd(STATUS_OFS, 32'h10, 32'h10, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h05);
      rd(STATUS_OFS, 32'h12, 32'h02, 1'b0);
      vcc_mv <= 16'h4843;
      cyc(3);
      chk(cur_gen_en, 32'h0);
      vcc_mv <= 16'h5DC0;
      cyc(3);
      rd(STATUS_OFS, 32'h20, 32'h20, 1'b0);
      apb(1'b1, CTRL_OFS, 32'h05);
      rd(STATUS_OFS, 32'h30, 32'h0, 1'b0);
      vlas_mv <= 16'h4448;
      cyc(3);
      rd(STATUS_OFS, 32'h10, 32'h0, 1'b0);
      vlas_mv <= 16'h4449;
      cyc(3);
      rd(STATUS_OFS, 32'h10, 32'h10, 1'b0);
      vlas_mv <= 16'h07D0;
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, CTRL_OFS, s ? 32'h04 : 32'h14);
         for (int k = 0; k < 12; k++) begin
            v = s ? ch1 : ch2;
            @(posedge core_clk);
            chk(sync_out, v);
         end
      end
      apb(1'b1, CTRL_OFS, 32'h05);
      apb(1'b1, ERR_LIM_OFS, 32'h64);
      for (int k = 0; k < 100 && tstab_en !== 1'b0; k++) cyc(1);
      cyc(1);
      chk(tstab_en, 32'h0);
      chk(cur_gen_en, 32'h0);
      rd(STATUS_OFS, 32'h300, 32'h300, 1'b0);
      // Temperature swings across the setpoint every sample, so the sum
      // keeps restarting and stays below the low limit of 100.
      apb(1'b1, CTRL_OFS, 32'h04);
      for (int k = 0; k < 10; k++) begin
         temp_now <= k[0] ? 32'h0000_61E4 : 32'h0000_616C;
         cyc(8);
      end
      chk(tstab_en, 32'h1);
      rd(STATUS_OFS, 32'h200, 32'h0, 1'b0);
      cyc(2);
      tally_and_finish();
   end
endmodule
